// File: core/fdt_pwm_tick.v
`timescale 1ns/1ps
// divides the system clock down to the pwm timebase, one pulse per period
module fdt_pwm_tick #(
	parameter PWM_CYCLES = 6250
) (
	input  wire sys_clk,  // system clock
	input  wire resetn,   // async reset, active low
	output reg  tick_q    // one-cycle pulse per pwm period
);
	// cut to the counter width on purpose; the default period fits easily
	localparam integer LAST_I = PWM_CYCLES - 1;
	localparam [15:0]  LAST   = LAST_I[15:0];

	reg [15:0] cnt_q;

	// free running, so the fade and reset-run timing never depend on bus clock
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (cnt_q == LAST) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end
endmodule // fdt_pwm_tick

// File: core/fdt_regs.vh
`ifndef FDT_REGS_VH
`define FDT_REGS_VH

// register map, byte addresses on the serial register port
`define FDT_ADDR_CFG         8'h10
`define FDT_ADDR_FADE_OUT    8'h11
`define FDT_ADDR_FADE_IN     8'h12

// configuration register bit positions
`define FDT_CFG_RUN          0
`define FDT_CFG_RRUN_EN      1
`define FDT_CFG_STAT_UP      3
`define FDT_CFG_STAT_DOWN    4
`define FDT_CFG_STAT_HOLD    5
`define FDT_CFG_PIN_REGRST   6
`define FDT_CFG_WMASK        8'h43

// timing field positions in the fade registers
`define FDT_DELAY_MSB        5
`define FDT_DELAY_LSB        3
`define FDT_RAMP_MSB         2
`define FDT_RAMP_LSB         0

// power-on values
`define FDT_CFG_RESET        8'h00
`define FDT_FADE_OUT_RESET   8'h00
`define FDT_FADE_IN_RESET    8'h00

// clocks and times
`define FDT_CLK_HZ           200000000
`define FDT_PWM_HZ           32000
`define FDT_PWM_CYCLES       (`FDT_CLK_HZ / `FDT_PWM_HZ)
`define FDT_FADE_BASE_US     65500
`define FDT_FADE_BASE_TICKS  (`FDT_FADE_BASE_US * (`FDT_PWM_HZ / 1000) / 1000)
`define FDT_FADE_STEPS       8
`define FDT_STEP_BASE_TICKS  (`FDT_FADE_BASE_TICKS / `FDT_FADE_STEPS)
`define FDT_RRUN_PERIODS     128

`endif

// File: core/fdt_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for one asynchronous level
module fdt_sync #(
	parameter RESET_VAL = 1'b0
) (
	input  wire sys_clk,   // system clock
	input  wire resetn,    // async reset, active low
	input  wire async_in,  // level from a pin
	output reg  sync_q     // synchronised level
);
	reg meta_q;

	// first stage feeds only the second stage
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule // fdt_sync

// File: core/fdt_top.v
`timescale 1ns/1ps
`include "fdt_regs.vh"

module fdt_top #(
	parameter PWM_CYCLES      = `FDT_PWM_CYCLES,
	parameter STEP_BASE_TICKS = `FDT_STEP_BASE_TICKS,
	parameter RRUN_PERIODS    = `FDT_RRUN_PERIODS
) (
	input  wire       sys_clk,      // system clock, 200 MHz
	input  wire       resetn,       // async reset, active low
	input  wire       rst_pin_n,    // reset pin, active low, asynchronous
	input  wire       slave_ack,    // pulse: serial engine acked our address
	input  wire       reg_we,       // pulse: register write from serial engine
	input  wire [7:0] reg_addr,     // register address
	input  wire [7:0] reg_wdata,    // register write data
	output reg  [7:0] reg_rdata_q,  // read data, one cycle after reg_addr
	output reg        bus_enable_q, // high while serial engine may respond
	output reg        bus_abort_q,  // pulse: return serial engine to idle
	output reg        drive_en_q,   // constant-current outputs enabled
	output reg  [2:0] fade_level_q, // fade dac code, 7 is full current
	output reg        run_q         // configuration run bit
);
	localparam [2:0] S_OFF  = 3'd0;
	localparam [2:0] S_HOLD = 3'd1;
	localparam [2:0] S_DOWN = 3'd2;
	localparam [2:0] S_UP   = 3'd3;
	localparam [2:0] S_ON   = 3'd4;

	// cut to the counter widths on purpose; the defaults fit with room to spare
	localparam integer STEP_BASE_I = STEP_BASE_TICKS;
	localparam integer RR_LAST_I   = RRUN_PERIODS;
	localparam [14:0]  STEP_BASE   = STEP_BASE_I[14:0];
	localparam [7:0]   RR_LAST     = RR_LAST_I[7:0];

	wire       pin_s;
	wire       tick;
	reg        pin_d1_q;
	reg  [7:0] cfg_q;
	reg  [7:0] fade_out_q;
	reg  [7:0] fade_in_q;
	reg        run_prev_q;
	reg        armed_q;
	reg  [7:0] rr_cnt_q;
	reg  [2:0] state_q;
	reg  [2:0] state_d;
	reg  [2:0] phase_q;
	reg  [2:0] phase_d;
	reg  [14:0] step_q;
	reg  [14:0] step_d;
	reg  [2:0] lvl_d;
	reg        drv_d;
	reg  [2:0] seg_code;
	reg  [7:0] rdata_d;

	// reset pin crosses into the system clock domain
	fdt_sync #(
		.RESET_VAL (1'b0)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (rst_pin_n),
		.sync_q   (pin_s)
	);

	fdt_pwm_tick #(
		.PWM_CYCLES (PWM_CYCLES)
	) u_tick (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.tick_q  (tick)
	);

	wire       pin_rise  = pin_s & ~pin_d1_q;
	wire       pin_fall  = ~pin_s & pin_d1_q;
	wire       bus_live  = pin_s & pin_d1_q;
	wire       ack_ok    = slave_ack & bus_live;
	wire       wr_ok     = reg_we & bus_live;
	wire       rr_fire   = armed_q & tick & (rr_cnt_q == RR_LAST);
	wire       run_now   = cfg_q[`FDT_CFG_RUN];
	wire       run_fall  = run_prev_q & ~run_now;
	wire       run_rise  = ~run_prev_q & run_now;
	wire [2:0] delay_code = fade_out_q[`FDT_DELAY_MSB:`FDT_DELAY_LSB];
	wire [2:0] down_code  = fade_out_q[`FDT_RAMP_MSB:`FDT_RAMP_LSB];
	wire [2:0] up_code    = fade_in_q[`FDT_RAMP_MSB:`FDT_RAMP_LSB];
	wire [2:0] shift_amt  = seg_code - 3'd1;
	// each code step doubles the segment length
	wire [14:0] step_len  = STEP_BASE << shift_amt;
	wire       step_done = (step_q == step_len - 15'd1);

	// pin edge tracking and bus gating
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_d1_q     <= 1'b0;
			bus_enable_q <= 1'b0;
			bus_abort_q  <= 1'b0;
		end else begin
			pin_d1_q     <= pin_s;
			bus_enable_q <= pin_s;
			bus_abort_q  <= pin_fall;
		end
	end

	// register file; hardware updates land after the write so a hardware set or clear wins
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q      <= `FDT_CFG_RESET;
			fade_out_q <= `FDT_FADE_OUT_RESET;
			fade_in_q  <= `FDT_FADE_IN_RESET;
		end else if (!pin_s && cfg_q[`FDT_CFG_PIN_REGRST]) begin
			cfg_q      <= `FDT_CFG_RESET;
			fade_out_q <= `FDT_FADE_OUT_RESET;
			fade_in_q  <= `FDT_FADE_IN_RESET;
		end else begin
			if (wr_ok && reg_addr == `FDT_ADDR_CFG) begin
				cfg_q <= reg_wdata & `FDT_CFG_WMASK;
			end
			// full bytes stored and read back
			if (wr_ok && reg_addr == `FDT_ADDR_FADE_OUT) begin
				fade_out_q <= reg_wdata;
			end
			if (wr_ok && reg_addr == `FDT_ADDR_FADE_IN) begin
				fade_in_q <= reg_wdata;
			end
			if (armed_q && ack_ok) begin
				cfg_q[`FDT_CFG_RRUN_EN] <= 1'b0;
			end
			if (rr_fire) begin
				cfg_q[`FDT_CFG_RUN] <= 1'b1;
			end
		end
	end

	// reset-run trigger: armed by a rising pin edge, counted in pwm periods
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			armed_q  <= 1'b0;
			rr_cnt_q <= 8'h00;
		end else if (!pin_s) begin
			armed_q  <= 1'b0;
			rr_cnt_q <= 8'h00;
		end else if (pin_rise) begin
			armed_q  <= cfg_q[`FDT_CFG_RRUN_EN];
			rr_cnt_q <= 8'h00;
		end else if (armed_q && ack_ok) begin
			armed_q  <= 1'b0;
			rr_cnt_q <= 8'h00;
		end else if (armed_q && tick) begin
			// first tick lands 0..1 period after the edge, so the
			// extra count makes the quiet time 128 to 129 periods
			if (rr_cnt_q == RR_LAST) begin
				armed_q  <= 1'b0;
				rr_cnt_q <= 8'h00;
			end else begin
				rr_cnt_q <= rr_cnt_q + 8'h01;
			end
		end
	end

	// segment length follows the code of the segment in progress
	always @* begin
		case (state_q)
			S_HOLD:  seg_code = delay_code;
			S_DOWN:  seg_code = down_code;
			S_UP:    seg_code = up_code;
			default: seg_code = 3'd1;
		endcase
	end

	// fade sequencer: each segment is eight steps of step_len pwm ticks
	always @* begin
		state_d = state_q;
		phase_d = phase_q;
		step_d  = step_q;
		lvl_d   = fade_level_q;
		drv_d   = drive_en_q;
		if (run_fall) begin
			phase_d = 3'd0;
			step_d  = 15'h0000;
			if (delay_code != 3'd0) begin
				state_d = S_HOLD;
				lvl_d   = 3'd7;
				drv_d   = 1'b1;
			end else if (down_code != 3'd0) begin
				state_d = S_DOWN;
				lvl_d   = 3'd7;
				drv_d   = 1'b1;
			end else begin
				// code 000 switches off at once
				state_d = S_OFF;
				lvl_d   = 3'd0;
				drv_d   = 1'b0;
			end
		end else if (run_rise) begin
			phase_d = 3'd0;
			step_d  = 15'h0000;
			drv_d   = 1'b1;
			if (up_code != 3'd0) begin
				state_d = S_UP;
				lvl_d   = 3'd0;
			end else begin
				state_d = S_ON;
				lvl_d   = 3'd7;
			end
		end else if (tick && (state_q == S_HOLD || state_q == S_DOWN || state_q == S_UP)) begin
			if (!step_done) begin
				step_d = step_q + 15'h0001;
			end else begin
				step_d  = 15'h0000;
				phase_d = phase_q + 3'd1;
				case (state_q)
					S_HOLD: begin
						if (phase_q == 3'd7) begin
							if (down_code != 3'd0) begin
								state_d = S_DOWN;
							end else begin
								state_d = S_OFF;
								lvl_d   = 3'd0;
								drv_d   = 1'b0;
							end
						end
					end
					S_DOWN: begin
						if (phase_q == 3'd7) begin
							state_d = S_OFF;
							lvl_d   = 3'd0;
							drv_d   = 1'b0;
						end else begin
							lvl_d = fade_level_q - 3'd1;
						end
					end
					S_UP: begin
						if (phase_q == 3'd7) begin
							state_d = S_ON;
						end else begin
							lvl_d = fade_level_q + 3'd1;
						end
					end
					default: begin
						state_d = S_OFF;
					end
				endcase
			end
		end
	end

	// fade state registers; outputs start off since run resets low
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q      <= S_OFF;
			phase_q      <= 3'd0;
			step_q       <= 15'h0000;
			fade_level_q <= 3'd0;
			drive_en_q   <= 1'b0;
			run_prev_q   <= 1'b0;
			run_q        <= 1'b0;
		end else begin
			state_q      <= state_d;
			phase_q      <= phase_d;
			step_q       <= step_d;
			fade_level_q <= lvl_d;
			drive_en_q   <= drv_d;
			run_prev_q   <= run_now;
			run_q        <= run_now;
		end
	end

	// read mux; status bits show the sequencer, unmapped addresses read zero
	always @* begin
		case (reg_addr)
			`FDT_ADDR_CFG: begin
				rdata_d = cfg_q;
				rdata_d[`FDT_CFG_STAT_UP]   = (state_q == S_UP);
				rdata_d[`FDT_CFG_STAT_DOWN] = (state_q == S_DOWN);
				rdata_d[`FDT_CFG_STAT_HOLD] = (state_q == S_HOLD);
			end
			`FDT_ADDR_FADE_OUT: rdata_d = fade_out_q;
			`FDT_ADDR_FADE_IN:  rdata_d = fade_in_q;
			default:            rdata_d = 8'h00;
		endcase
	end

	// registered read data
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= rdata_d;
		end
	end
endmodule // fdt_top

// File: test/fdt_host_model.sv
`timescale 1ns/1ps
// host end of the serial bus: an address phase that ends in one ack pulse
module fdt_host_model (
	input  wire       sys_clk,   // system clock
	input  wire       resetn,    // async reset, active low
	input  wire       go,        // start an address phase
	input  wire [3:0] lag,       // ack comes lag plus two clock cycles after go
	output logic      slave_ack  // one-cycle acknowledge
);
	logic [4:0] cnt_q;
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= 5'h00;
			slave_ack <= 1'b0;
		end else begin
			slave_ack <= cnt_q == 5'h01;
			cnt_q <= go ? {1'b0, lag} + 5'h02 : cnt_q - {4'h0, cnt_q != 5'h00};
		end
	end
endmodule // fdt_host_model

// File: test/fdt_top_asserts.sv
`timescale 1ns/1ps
module fdt_chk (
	input wire       sys_clk,      // system clock
	input wire       resetn,       // async reset, active low
	input wire       rst_pin_n,    // reset pin
	input wire       slave_ack,    // address acked
	input wire       reg_we,       // register write
	input wire [7:0] reg_addr,     // register address
	input wire [7:0] reg_wdata,    // write data
	input wire [7:0] reg_rdata_q,  // read data
	input wire       bus_enable_q, // serial engine live
	input wire       bus_abort_q,  // serial engine abort
	input wire       drive_en_q,   // outputs on
	input wire [2:0] fade_level_q, // fade code
	input wire       run_q         // run bit
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// pin side: abort once per fall, bus follows the pin after the synchroniser
	abort_on_fall_a: assert property ($fell(rst_pin_n) |-> ##[1:4] bus_abort_q)
		else $error("no abort after pin fall");
	abort_single_a: assert property (bus_abort_q |=> !bus_abort_q)
		else $error("abort longer than one cycle");
	bus_gated_a: assert property (!rst_pin_n [*3] |=> !bus_enable_q)
		else $error("bus live while pin low");
	bus_live_a: assert property (rst_pin_n [*4] |=> bus_enable_q)
		else $error("bus dead while pin high");
	// register side: read back, empty places and reserved bits read zero
	fade_readback_a: assert property (
		reg_we && bus_enable_q && reg_addr == 8'h11 ##1
		reg_addr == 8'h11 |=> reg_rdata_q == $past(reg_wdata, 2))
		else $error("fade out readback wrong");
	unmapped_zero_a: assert property ((reg_addr < 8'h10 || reg_addr > 8'h12) |=>
		reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	cfg_reserved_a: assert property (reg_addr == 8'h10 |=> !reg_rdata_q[7] && !reg_rdata_q[2])
		else $error("reserved cfg bit set");
	run_write_a: assert property (reg_we && bus_enable_q && reg_addr == 8'h10 |->
		##2 run_q == $past(reg_wdata[0], 2))
		else $error("run bit not written");
	// main scenarios
	cover property (!$past(reg_we, 2) && $rose(run_q));
	cover property (drive_en_q && fade_level_q == 3'h3);
	cover property (slave_ack && bus_enable_q);
endmodule // fdt_chk

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int P = 8;
	localparam int S = 2;
	localparam int R = 4;
	logic        sys_clk = 0, resetn = 0, pin_n = 0, we = 0, go = 0, mk = 0, sn = 0;
	logic [7:0]  ad = 0, wd = 0, rdq;
	logic [3:0]  lag = 0;
	logic        ack, en, ab, dv, run;
	logic [2:0]  lv;
	logic [31:0] rng = 32'hcde1_ab5c;
	logic [7:0]  eq[$];
	string       nq[$];
	int          bad_count = 0, num_checks = 0, cyc = 0, n;
	// clock
	always #2.5 sys_clk = ~sys_clk;
	fdt_top #(.PWM_CYCLES(P), .STEP_BASE_TICKS(S), .RRUN_PERIODS(R)) uut (.sys_clk(sys_clk),
		.resetn(resetn), .rst_pin_n(pin_n), .slave_ack(ack), .reg_we(we), .reg_addr(ad),
		.reg_wdata(wd), .reg_rdata_q(rdq), .bus_enable_q(en), .bus_abort_q(ab),
		.drive_en_q(dv), .fade_level_q(lv), .run_q(run));
	fdt_host_model host (.sys_clk(sys_clk), .resetn(resetn), .go(go), .lag(lag), .slave_ack(ack));
	function automatic logic [31:0] xs(logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(string nm, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic tk(int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		we = 1;
		ad = a;
		wd = d;
		tk(1);
		we = 0;
		// let an edge pass so a following write never re-raises the strobe in this step
		tk(1);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
		ad = a;
		eq.push_back(e);
		nq.push_back(nm);
		mk = 1;
		tk(1);
		mk = 0;
		tk(1);
	endtask
	// time a fade; quantised to pwm ticks, so the window allows a tick or two
	task automatic span(bit up, int st, int c, string nm);
		int k = 0;
		int e = st * (S << (c - 1)) * P;
		while ((up ? lv !== 3'h7 : dv !== 1'b0) && k < 9000) begin
			tk(1);
			k++;
		end
		check(nm, 8'(k >= e - P && k <= e + 2 * P + 4), 8'h01);
	endtask
	// scoreboard: a read lands one edge after its address
	always @(posedge sys_clk) sn <= mk;
	always @(negedge sys_clk) if (sn) check(nq.pop_front(), rdq, eq.pop_front());
	// hang guard, the run needs about 52k cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 70000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		tk(5);
		resetn = 1;
		pin_n = 1;
		tk(5);
		for (int i = 0; i < 5; i++) rd(i < 4 ? 8'(16 + i) : 8'hff, 8'h00, "reset value");
		rng = xs(rng);
		wr(8'h11, rng[7:0]);
		wr(8'h12, rng[15:8]);
		wr(8'h10, rng[23:16] & 8'hfc);
		rd(8'h11, rng[7:0], "fade out");
		rd(8'h12, rng[15:8], "fade in");
		rd(8'h10, rng[23:16] & 8'h40, "cfg");
		wr(8'h12, 8'h00);
		wr(8'h11, 8'h00);
		wr(8'h10, 8'h01);
		tk(2);
		check("on at once", {4'h0, dv, lv}, 8'h0f);
		wr(8'h10, 8'h00);
		tk(2);
		check("off at once", {4'h0, dv, lv}, 8'h00);
		$display("test registers done");
		for (int c = 1; c < 8; c++) begin
			wr(8'h12, 8'(c));
			wr(8'h10, 8'h01);
			span(1, 7, c, "fade in span");
			tk(S * P << c);
			wr(8'h11, 8'(c));
			wr(8'h10, 8'h00);
			span(0, 8, c, "fade out span");
			wr(8'h12, 8'h00);
			wr(8'h11, 8'(c << 3));
			wr(8'h10, 8'h01);
			tk(3);
			wr(8'h10, 8'h00);
			tk(S * P << (c + 1));
			check("hold full", {4'h0, dv, lv}, 8'h0f);
			span(0, 4, c, "hold span");
		end
		$display("test fades done");
		wr(8'h11, 8'h5a);
		pin_n = 0;
		tk(4);
		wr(8'h11, 8'ha5);
		rd(8'h11, 8'h5a, "write while pin low");
		pin_n = 1;
		tk(4);
		wr(8'h10, 8'h42);
		pin_n = 0;
		tk(4);
		rd(8'h11, 8'h00, "pin reset fade out");
		rd(8'h10, 8'h00, "pin reset cfg");
		pin_n = 1;
		tk(4);
		wr(8'h10, 8'h02);
		pin_n = 0;
		go = 1;
		tk(1);
		go = 0;
		tk(30);
		pin_n = 1;
		tk(R * P - 12);
		pin_n = 0;
		tk(3 * R * P);
		check("short pulse", {7'h0, run}, 8'h00);
		pin_n = 1;
		n = 0;
		while (run !== 1'b1 && n < 500) begin
			tk(1);
			n++;
		end
		check("reset-run delay", 8'(n >= R * P && n <= (R + 1) * P + 8), 8'h01);
		check("run after trigger", {6'h0, dv, run}, 8'h03);
		rd(8'h10, 8'h03, "cfg after trigger");
		wr(8'h10, 8'h02);
		pin_n = 0;
		tk(4);
		pin_n = 1;
		tk(6);
		rng = xs(rng);
		lag = rng[3:0];
		go = 1;
		tk(1);
		go = 0;
		tk(3 * R * P);
		check("cancelled run", {7'h0, run}, 8'h00);
		rd(8'h10, 8'h00, "cfg after cancel");
		$display("test reset pin done");
		conclude();
	end
endmodule // testbench
bind fdt_top fdt_chk chk (.sys_clk(sys_clk), .resetn(resetn), .rst_pin_n(rst_pin_n),
	.slave_ack(slave_ack), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata_q(reg_rdata_q), .bus_enable_q(bus_enable_q), .bus_abort_q(bus_abort_q),
	.drive_en_q(drive_en_q), .fade_level_q(fade_level_q), .run_q(run_q));
